// *** rtl/sil_regs.svh ***
// register map, field positions, reset values and timing counts
// assumes a 125 MHz system clock and a 32-bit avalon-mm slave
`ifndef SIL_REGS_SVH
`define SIL_REGS_SVH
`define SIL_OFS_CTRL        6'h00
`define SIL_OFS_LED_MODE    6'h04
`define SIL_OFS_OVER_START  6'h08
`define SIL_OFS_OVER_TIME   6'h0c
`define SIL_OFS_UNDER_START 6'h10
`define SIL_OFS_STATUS      6'h14
`define SIL_OFS_IRQ_STAT    6'h18
`define SIL_OFS_IRQ_MASK    6'h1c
`define SIL_OFS_FAULT_CODE  6'h20
`define SIL_CTRL_CLEAR_A    0
`define SIL_CTRL_CLEAR_B    1
`define SIL_CTRL_INVERSE_TIME_MODE       2
`define SIL_CTRL_RANGE_LO   3
`define SIL_CTRL_RANGE_HI   4
`define SIL_CTRL_FAULT      5
`define SIL_OVER_START_MIN  16'h0050
`define SIL_OVER_START_MAX  16'h00a0
`define SIL_OVER_START_RST  16'h0050
`define SIL_UNDER_START_MIN 16'h0028
`define SIL_UNDER_START_MAX 16'h0078
`define SIL_UNDER_START_RST 16'h0028
`define SIL_TIME_R0_MIN     16'h0005
`define SIL_TIME_R0_MAX     16'h0064
`define SIL_TIME_R1_MIN     16'h0032
`define SIL_TIME_R1_MAX     16'h03e8
`define SIL_TIME_R2_MIN     16'h01f4
`define SIL_TIME_R2_MAX     16'h2710
`define SIL_TIME_K_MIN      16'h0005
`define SIL_TIME_K_MAX      16'h0064
`define SIL_TIME_RST        16'h0005
`define SIL_ALARM_DELAY_NS  1000
`define SIL_CLK_NS          8
`define SIL_ALARM_CYCLES \
    ((`SIL_ALARM_DELAY_NS + `SIL_CLK_NS - 1) / `SIL_CLK_NS)
`endif

// *** rtl/sil_pkg.sv ***
// shared types of the stage indicator logic
// assumes sil_regs.svh supplies every number
package sil_pkg;
    typedef logic [1:0] sil_colour_t; // bit1 red, bit0 yellow
    typedef enum logic [1:0] {
        SIL_IDLE  = 2'b00,
        SIL_WAIT  = 2'b01,
        SIL_ALARM = 2'b11
    } sil_alarm_state_t;
endpackage : sil_pkg

// *** rtl/sil_led.sv ***
// one indicator light: self-clearing or latched
// assumes src is already synchronised to clk_sys
`timescale 1ns/1ps
module sil_led (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // control
    input  wire logic src,
    input  wire logic latch_mode,
    input  wire logic clear,
    // light
    output logic      lit
);
    logic next_lit;
    logic held;
    logic next_held;

    always_comb begin
        // a new event wins over a clear in the same cycle
        next_held = latch_mode & (src | (held & ~clear)); // [R4] [R7]
        next_lit  = latch_mode ? next_held : src;          // [R3] [R6]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            held <= 1'b0;
            lit  <= 1'b0;
        end else begin
            held <= next_held;
            lit  <= next_lit;
        end
    end
endmodule : sil_led

// *** rtl/sil_top.sv ***
// stage start/trip indicators, fault alarm and setting limits
// assumes stage inputs come from other domains, pins are raw
// Functional notes
// R1 - each stage has its own two-colour indicator
// R2 - yellow while started, red after trip
// R3 - four lights each self-clearing or latching
// R4 - latched light stays on after stage resets
// R5 - start self-clear, trip latched: yellow then red
// R6 - start without trip: yellow only while started
// R7 - panel button or remote commands clear latches
// R8 - lights never gate start or trip
// R9 - fault alarm lights red shortly after fault
// R10 - alarm relay output asserted with alarm light
// R11 - fault code shown on module display
// R12 - overvoltage start value limited to 0.8..1.6
// R13 - two switches pick one of three time ranges
// R14 - inverse mode multiplier limited to 0.05..1.00
// R15 - undervoltage start value limited to 0.4..1.2
// R16 - red wins over yellow on one indicator
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "sil_regs.svh"
module sil_top (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // avalon-mm slave
    input  wire logic [5:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // stage signals and panel
    input  wire logic                 over_stage_start,
    input  wire logic                 over_stage_trip,
    input  wire logic                 under_stage_start,
    input  wire logic                 under_stage_trip,
    input  wire logic                 panel_clear_btn,
    input  wire logic                 internal_fault,
    input  wire logic [7:0]           internal_fault_code,
    // indicators and outputs
    output sil_pkg::sil_colour_t      over_indicator,
    output sil_pkg::sil_colour_t      under_indicator,
    output logic                      internal_fault_alarm,
    output logic                      alarm_relay,
    output logic [7:0]                display_code,
    output logic                      irq
);
    import sil_pkg::*;

    // synchronisers: first stage feeds only the second
    logic [6:0] sync1;
    logic [6:0] sync2;
    // the code word is read only after the fault flag has stood for
    // the whole alarm delay, so its bits have long since settled
    logic [7:0] code_s1;
    logic [7:0] code_s2;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1   <= 7'h00;
            sync2   <= 7'h00;
            code_s1 <= 8'h00;
            code_s2 <= 8'h00;
        end else begin
            sync1   <= {internal_fault, panel_clear_btn, under_stage_trip,
                        under_stage_start, over_stage_trip,
                        over_stage_start, 1'b0};
            sync2   <= sync1;
            code_s1 <= internal_fault_code;
            code_s2 <= code_s1;
        end
    end
    logic s_os;
    logic s_ot;
    logic s_us;
    logic s_ut;
    logic s_btn;
    logic s_flt;
    logic s_btn_d;
    assign s_os  = sync2[1];
    assign s_ot  = sync2[2];
    assign s_us  = sync2[3];
    assign s_ut  = sync2[4];
    assign s_btn = sync2[5];
    assign s_flt = sync2[6];

    // registers
    logic [3:0]  led_mode;
    logic        inverse_time_mode;
    logic [1:0]  time_range;
    logic [15:0] over_start;
    logic [15:0] over_time;
    logic [15:0] under_start;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic        rd_pend;
    logic [3:0]  next_led_mode;
    logic        next_inverse_time_mode;
    logic [1:0]  next_time_range;
    logic [15:0] next_over_start;
    logic [15:0] next_over_time;
    logic [15:0] next_under_start;
    logic [3:0]  next_irq_stat;
    logic [3:0]  next_irq_mask;
    logic        next_rd_pend;
    logic [31:0] next_readdata;
    logic        next_waitrequest;
    logic        remote_clear;
    logic        next_btn_d;

    // clamping rather than refusing leaves no stale setting behind
    function automatic logic [15:0] sil_clamp(input logic [15:0] v,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
        sil_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : sil_clamp

    logic [15:0] t_lo;
    logic [15:0] t_hi;
    always_comb begin
        // settings outside the range are pulled to the nearest limit
        if (next_inverse_time_mode) begin
            t_lo = `SIL_TIME_K_MIN;                       // [R14]
            t_hi = `SIL_TIME_K_MAX;
        end else begin
            unique case (next_time_range)                 // [R13]
                2'b00: begin
                    t_lo = `SIL_TIME_R0_MIN;
                    t_hi = `SIL_TIME_R0_MAX;
                end
                2'b01, 2'b10: begin
                    t_lo = `SIL_TIME_R1_MIN;
                    t_hi = `SIL_TIME_R1_MAX;
                end
                2'b11: begin
                    t_lo = `SIL_TIME_R2_MIN;
                    t_hi = `SIL_TIME_R2_MAX;
                end
            endcase
        end
    end

    logic       wr_hit;
    logic [3:0] events;
    logic [3:0] ev_prev;
    logic [3:0] next_ev_prev;
    logic [3:0] ev_rise;
    assign events  = {s_flt, s_ut, s_us | s_os, s_ot};
    assign ev_rise = events & ~ev_prev;

    always_comb begin
        next_led_mode    = led_mode;
        next_inverse_time_mode        = inverse_time_mode;
        next_time_range  = time_range;
        next_over_start  = over_start;
        next_over_time   = over_time;
        next_under_start = under_start;
        next_irq_mask    = irq_mask;
        next_readdata    = avs_readdata;
        next_rd_pend     = 1'b0;
        next_waitrequest = 1'b1;
        remote_clear     = 1'b0;
        next_btn_d       = s_btn;
        next_ev_prev     = events;
        // a write lands at the edge that completes the transfer
        wr_hit           = avs_write & ~avs_waitrequest & avs_byteenable[0];
        // set wins over write-one-to-clear
        next_irq_stat    = irq_stat;
        if (wr_hit && avs_address == `SIL_OFS_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~avs_writedata[3:0];
        end
        next_irq_stat = next_irq_stat | ev_rise;
        if (avs_write) begin
            // low for the one cycle after the request is seen
            next_waitrequest = ~avs_waitrequest;
            if (wr_hit) begin
                unique case (avs_address)
                    `SIL_OFS_CTRL: begin
                        remote_clear = avs_writedata[`SIL_CTRL_CLEAR_A] |
                                       avs_writedata[`SIL_CTRL_CLEAR_B];
                        next_inverse_time_mode = avs_writedata[`SIL_CTRL_INVERSE_TIME_MODE];
                        next_time_range =
                            avs_writedata[`SIL_CTRL_RANGE_HI:
                                          `SIL_CTRL_RANGE_LO];
                    end
                    `SIL_OFS_LED_MODE: next_led_mode = avs_writedata[3:0];
                    `SIL_OFS_OVER_START: next_over_start = sil_clamp(
                        avs_writedata[15:0], `SIL_OVER_START_MIN,
                        `SIL_OVER_START_MAX);                   // [R12]
                    `SIL_OFS_UNDER_START: next_under_start = sil_clamp(
                        avs_writedata[15:0], `SIL_UNDER_START_MIN,
                        `SIL_UNDER_START_MAX);                  // [R15]
                    `SIL_OFS_IRQ_MASK: next_irq_mask = avs_writedata[3:0];
                    default: ;
                endcase
            end
        end else if (avs_read && avs_waitrequest && !rd_pend) begin
            // the answering edge must not open a second read
            next_rd_pend = 1'b1;
        end else if (avs_read && rd_pend) begin
            next_waitrequest = 1'b0;
            unique case (avs_address)
                `SIL_OFS_CTRL: next_readdata = {26'h0, s_flt, time_range,
                                                inverse_time_mode, 2'b00};
                `SIL_OFS_LED_MODE:    next_readdata = {28'h0, led_mode};
                `SIL_OFS_OVER_START:  next_readdata = {16'h0, over_start};
                `SIL_OFS_OVER_TIME:   next_readdata = {16'h0, over_time};
                `SIL_OFS_UNDER_START: next_readdata = {16'h0, under_start};
                `SIL_OFS_STATUS: next_readdata = {26'h0, s_flt, s_ut, s_us,
                                                  s_ot, s_os, 1'b0};
                `SIL_OFS_IRQ_STAT:    next_readdata = {28'h0, irq_stat};
                `SIL_OFS_IRQ_MASK:    next_readdata = {28'h0, irq_mask};
                `SIL_OFS_FAULT_CODE:  next_readdata = {24'h0, display_code};
                default:              next_readdata = 32'h0;
            endcase
        end
        // time write clamps against the range that is in force after
        // this write, so range and value stay consistent
        if (wr_hit && avs_address == `SIL_OFS_OVER_TIME) begin
            next_over_time = sil_clamp(avs_writedata[15:0], t_lo, t_hi);
        end else begin
            next_over_time = sil_clamp(over_time, t_lo, t_hi); // [R13]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            led_mode        <= 4'h0;
            inverse_time_mode            <= 1'b0;
            time_range      <= 2'b00;
            over_start      <= `SIL_OVER_START_RST;
            over_time       <= `SIL_TIME_RST;
            under_start     <= `SIL_UNDER_START_RST;
            irq_stat        <= 4'h0;
            irq_mask        <= 4'h0;
            rd_pend         <= 1'b0;
            avs_readdata    <= 32'h0;
            avs_waitrequest <= 1'b1;
            s_btn_d         <= 1'b0;
            ev_prev         <= 4'h0;
        end else begin
            led_mode        <= next_led_mode;
            inverse_time_mode            <= next_inverse_time_mode;
            time_range      <= next_time_range;
            over_start      <= next_over_start;
            over_time       <= next_over_time;
            under_start     <= next_under_start;
            irq_stat        <= next_irq_stat;
            irq_mask        <= next_irq_mask;
            rd_pend         <= next_rd_pend;
            avs_readdata    <= next_readdata;
            avs_waitrequest <= next_waitrequest;
            s_btn_d         <= next_btn_d;
            ev_prev         <= next_ev_prev;
        end
    end

    // clear pulse from button edge or remote command
    // a held button clears once, so a later event can relatch
    logic clear_all;
    assign clear_all = (s_btn & ~s_btn_d) | remote_clear;   // [R7]

    // four lights; stage inputs bypass them entirely
    logic [3:0] lit;
    logic [3:0] led_src;
    assign led_src = {s_ut, s_us, s_ot, s_os};              // [R8]
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_led
            sil_led u_led (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .src        (led_src[gi]),
                .latch_mode (led_mode[gi]),                 // [R3]
                .clear      (clear_all),
                .lit        (lit[gi])
            );
        end
    endgenerate

    // internal fault alarm after a short qualifying delay
    sil_alarm_state_t st;
    sil_alarm_state_t next_st;
    logic [7:0]       cnt;
    logic [7:0]       next_cnt;
    logic [7:0]       next_code;
    sil_colour_t      next_over_ind;
    sil_colour_t      next_under_ind;
    logic             next_irq;
    always_comb begin
        next_st   = st;
        next_cnt  = cnt;
        next_code = display_code;
        unique case (st)
            SIL_IDLE: begin
                next_cnt = 8'h00;
                if (s_flt) begin
                    next_st = SIL_WAIT;
                end
            end
            SIL_WAIT: begin
                next_cnt = cnt + 8'h01;
                if (!s_flt) begin
                    next_st = SIL_IDLE;
                end else if (cnt == 8'(`SIL_ALARM_CYCLES - 1)) begin
                    next_st   = SIL_ALARM;                    // [R9]
                    next_code = code_s2;                      // [R11]
                end
            end
            SIL_ALARM: ;  // permanent fault holds until reset
            default: next_st = SIL_IDLE;
        endcase
        // red overrides yellow
        next_over_ind  = lit[1] ? 2'b10 : {1'b0, lit[0]};   // [R1] [R2] [R16]
        next_under_ind = lit[3] ? 2'b10 : {1'b0, lit[2]};   // [R5]
        next_irq       = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st                   <= SIL_IDLE;
            cnt                  <= 8'h00;
            display_code         <= 8'h00;
            over_indicator       <= 2'b00;
            under_indicator      <= 2'b00;
            internal_fault_alarm <= 1'b0;
            alarm_relay          <= 1'b0;
            irq                  <= 1'b0;
        end else begin
            st                   <= next_st;
            cnt                  <= next_cnt;
            display_code         <= next_code;
            over_indicator       <= next_over_ind;
            under_indicator      <= next_under_ind;
            internal_fault_alarm <= (next_st == SIL_ALARM);
            alarm_relay          <= (next_st == SIL_ALARM);  // [R10]
            irq                  <= next_irq;
        end
    end
endmodule : sil_top

// *** bench/sil_top_monitor.sv ***
// port assertions for the stage indicator block
// assumes a bind onto sil_top, one clock domain
`timescale 1ns/1ps
module sil_top_monitor (
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 rst,
    // bus handshake
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic                 avs_waitrequest,
    // stage and fault inputs
    input wire logic                 over_stage_trip,
    input wire logic                 under_stage_start,
    input wire logic                 under_stage_trip,
    input wire logic                 internal_fault,
    // indicators
    input wire sil_pkg::sil_colour_t over_indicator,
    input wire sil_pkg::sil_colour_t under_indicator,
    input wire logic                 internal_fault_alarm,
    input wire logic                 alarm_relay,
    input wire logic [7:0]           display_code
);
    import sil_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // five cycles covers the two-flop sync plus the light and indicator registers
    a_over_trip_red: assert property (
        over_stage_trip [*5] |-> over_indicator == 2'b10)
        else $error("over trip not red");
    a_under_trip_red: assert property (
        under_stage_trip [*5] |-> under_indicator == 2'b10)
        else $error("under trip not red");
    a_under_start_lit: assert property (
        under_stage_start [*5] |-> under_indicator != 2'b00)
        else $error("under start dark");
    a_colour_legal: assert property (
        over_indicator != 2'b11 && under_indicator != 2'b11)
        else $error("both colours at once");
    a_relay_with_alarm: assert property (
        alarm_relay == internal_fault_alarm)
        else $error("relay and alarm differ");
    a_alarm_latched: assert property (
        internal_fault_alarm |=> internal_fault_alarm)
        else $error("alarm dropped");
    a_alarm_after_fault: assert property (
        $rose(internal_fault_alarm) |-> $past(internal_fault, 100))
        else $error("alarm without lasting fault");
    a_code_held: assert property (
        internal_fault_alarm && $past(internal_fault_alarm)
        |-> $stable(display_code))
        else $error("fault code moved");
    a_wait_one: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_write_ack: assert property (
        $rose(avs_write) |-> ##[1:2] !avs_waitrequest)
        else $error("write not acked");
    a_read_ack: assert property (
        $rose(avs_read) |-> ##[1:3] !avs_waitrequest)
        else $error("read not acked");
endmodule : sil_top_monitor

// *** bench/sil_stage_model.sv ***
// stage comparators, panel button and self-supervision source
// assumes tasks are called by the bench from its main thread
`timescale 1ns/1ps
module sil_stage_model (
    // clock
    input wire logic  clk_sys,
    // comparator outputs
    output logic      over_stage_start,
    output logic      over_stage_trip,
    output logic      under_stage_start,
    output logic      under_stage_trip,
    // panel and supervision
    output logic      panel_clear_btn,
    output logic      internal_fault,
    output logic[7:0] internal_fault_code
);
    initial begin
        {over_stage_start, over_stage_trip} = 2'b00;
        {under_stage_start, under_stage_trip} = 2'b00;
        {panel_clear_btn, internal_fault} = 2'b00;
        internal_fault_code = 8'h00;
    end
    // a real stage never trips without being started
    task stage(input int s, input logic st, input logic tr);
        @(posedge clk_sys);
        if (s == 1) begin
            under_stage_start <= st;
            under_stage_trip  <= st & tr;
        end else begin
            over_stage_start <= st;
            over_stage_trip  <= st & tr;
        end
    endtask : stage
    // held long enough to pass the synchroniser
    task press;
        @(posedge clk_sys);
        panel_clear_btn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        panel_clear_btn <= 1'b0;
    endtask : press
    task fault(input logic [7:0] c);
        @(posedge clk_sys);
        internal_fault_code <= c;
        internal_fault      <= 1'b1;
    endtask : fault
endmodule : sil_stage_model

// *** bench/testbench.sv ***
// self-checking bench for sil_top over avalon-mm
// assumes sil_stage_model drives the stage side
`timescale 1ns/1ps
module testbench;
    import sil_pkg::*;
    logic        clk_sys, rst, avs_read, avs_write;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        avs_waitrequest, os, ot, us, ut, btn, flt;
    logic [7:0]  fcode, display_code;
    sil_colour_t over_indicator, under_indicator;
    logic        internal_fault_alarm, alarm_relay, irq;
    int          n_errors, compares, n;

    sil_top sil_top_i (.clk_sys, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hf),
        .avs_readdata, .avs_waitrequest, .over_stage_start(os),
        .over_stage_trip(ot), .under_stage_start(us),
        .under_stage_trip(ut), .panel_clear_btn(btn),
        .internal_fault(flt), .internal_fault_code(fcode),
        .over_indicator, .under_indicator, .internal_fault_alarm,
        .alarm_relay, .display_code, .irq);
    sil_stage_model sil_stage_model_i (.clk_sys,
        .over_stage_start(os), .over_stage_trip(ot),
        .under_stage_start(us), .under_stage_trip(ut),
        .panel_clear_btn(btn), .internal_fault(flt),
        .internal_fault_code(fcode));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task finish_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    // one bus cycle; released only at the edge that sees the ack
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        n = 0;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        if (w) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        chk(n < 100, 1'b1, "bus hang");
    endtask : bus

    task rd_chk(input logic [5:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0);
        chk(q, e, m);
    endtask : rd_chk

    task sc(input logic [4:0] c, input logic [5:0] a,
            input logic [15:0] d, input logic [15:0] e);
        bus(1'b1, 6'h00, {27'h0, c});
        bus(1'b1, a, {16'h0, d});
        rd_chk(a, {16'h0, e}, "setting clamp");
    endtask : sc

    task st(input int s, input logic a, input logic b);
        sil_stage_model_i.stage(s, a, b);
        repeat (6) @(posedge clk_sys);
    endtask : st

    function logic [1:0] ind(input int s);
        return (s == 1) ? under_indicator : over_indicator;
    endfunction : ind

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        n_errors = 0;
        compares = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        chk(over_indicator, 2'b00, "reset dark");
        chk(internal_fault_alarm, 1'b0, "reset alarm");
        rd_chk(6'h04, 32'h0, "mode reset");
        rd_chk(6'h08, 32'h50, "over start reset");
        rd_chk(6'h10, 32'h28, "under start reset");
        rd_chk(6'h0c, 32'h5, "time reset");
        bus(1'b1, 6'h3c, 32'hffff);
        rd_chk(6'h3c, 32'h0, "unmapped");
        sc(5'h00, 6'h08, 16'h0000, 16'h0050);
        sc(5'h00, 6'h08, 16'hffff, 16'h00a0);
        sc(5'h00, 6'h08, 16'h0064, 16'h0064);
        sc(5'h00, 6'h10, 16'h0000, 16'h0028);
        sc(5'h00, 6'h10, 16'hffff, 16'h0078);
        sc(5'h00, 6'h0c, 16'hffff, 16'h0064);
        sc(5'h08, 6'h0c, 16'hffff, 16'h03e8);
        sc(5'h10, 6'h0c, 16'h0000, 16'h0032);
        sc(5'h18, 6'h0c, 16'h0000, 16'h01f4);
        sc(5'h18, 6'h0c, 16'hffff, 16'h2710);
        sc(5'h04, 6'h0c, 16'hffff, 16'h0064);
        sc(5'h04, 6'h0c, 16'h0000, 16'h0005);
        bus(1'b1, 6'h1c, 32'h1);
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, 6'h04, 32'h0);
            st(s, 1'b1, 1'b0);
            chk(ind(s), 2'b01, "start yellow");
            chk(ind(1 - s), 2'b00, "other dark");
            st(s, 1'b1, 1'b1);
            chk(ind(s), 2'b10, "trip red");
            st(s, 1'b0, 1'b0);
            chk(ind(s), 2'b00, "self clear");
            bus(1'b1, 6'h04, 32'h2 << (2 * s));
            st(s, 1'b1, 1'b1);
            st(s, 1'b1, 1'b0);
            chk(ind(s), 2'b10, "red over start");
            rd_chk(6'h14, 32'h2 << (2 * s), "status live");
            st(s, 1'b0, 1'b0);
            chk(ind(s), 2'b10, "red kept");
            sil_stage_model_i.press();
            repeat (6) @(posedge clk_sys);
            chk(ind(s), 2'b00, "panel clear");
            bus(1'b1, 6'h04, 32'h1 << (2 * s));
            st(s, 1'b1, 1'b0);
            st(s, 1'b0, 1'b0);
            chk(ind(s), 2'b01, "yellow kept");
            bus(1'b1, 6'h00, 32'h1 << s);
            repeat (6) @(posedge clk_sys);
            chk(ind(s), 2'b00, "remote clear");
        end
        chk(irq, 1'b1, "irq trip");
        rd_chk(6'h18, 32'h7, "irq status");
        bus(1'b1, 6'h18, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b0, "irq cleared");
        bus(1'b1, 6'h1c, 32'h4);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b1, "irq unmasked");
        bus(1'b1, 6'h18, 32'h6);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b0, "irq all clear");
        bus(1'b1, 6'h00, 32'h0);
        bus(1'b1, 6'h1c, 32'h8);
        sil_stage_model_i.fault(8'h5a);
        n = 0;
        while (internal_fault_alarm !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        chk(n > 100 && n < 200, 1'b1, "alarm delay");
        chk(alarm_relay, 1'b1, "relay");
        chk(display_code, 8'h5a, "display code");
        rd_chk(6'h20, 32'h5a, "code register");
        rd_chk(6'h00, 32'h20, "ctrl fault bit");
        chk(irq, 1'b1, "irq fault");
        finish_test();
    end
endmodule : testbench

bind sil_top sil_top_monitor sil_top_monitor_i (.clk_sys, .rst,
    .avs_read, .avs_write, .avs_waitrequest, .over_stage_trip,
    .under_stage_start, .under_stage_trip, .internal_fault,
    .over_indicator, .under_indicator, .internal_fault_alarm,
    .alarm_relay, .display_code);
